/* File: rtl/ssr_serial_readout.sv */
// Conversion sequencer and serial readout of the sampling converter.
`timescale 1ns/10ps
// Overview of operation
// - Strobe up before clock 12 ends, down in clock 13: enter LSB-first repeat.
// - In repeat mode the next 11 clocks resend the result, LSB first.
// - Repeat mode powers down in clock 13 until the strobe changes again.
// - Strobe up then down before clock 13 aborts the conversion at once.
// - Any strobe fall releases the data output to high impedance.
// - Results are 12-bit two's complement, 7FF top, 800 bottom.
// - A strobe fall puts the sample-and-hold into hold.
// - Strobe low throughout and at clock 13 start: power down until rise.
module ssr_serial_readout (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        convertStrobe,
    input  wire logic        linkClk,
    input  wire logic [11:0] sampleOffsetBin,
    output logic             dataOut,
    output logic             dataOe,
    output logic             holdMode,
    output logic             powerDown,
    output logic             resultValid,
    output logic [11:0]      resultWord,
    input  wire logic        resultReady
);
    // ------------------------------------------------------------------
    // Synchronisers and edge detection
    // ------------------------------------------------------------------
    logic                strobeS1;
    logic                strobeS2;
    logic                strobeS3;
    logic                linkS1;
    logic                linkS2;
    logic                linkS3;
    logic [11:0]         sampS1;
    logic [11:0]         sampS2;
    logic                strobeFell;
    logic                strobeRose;
    logic                clkFall;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            strobeS1 <= 1'b1;
            strobeS2 <= 1'b1;
            strobeS3 <= 1'b1;
            linkS1   <= 1'b1;
            linkS2   <= 1'b1;
            linkS3   <= 1'b1;
            sampS1   <= ssr_pkg::CODE_RESET;
            sampS2   <= ssr_pkg::CODE_RESET;
        end else begin
            strobeS1 <= convertStrobe;
            strobeS2 <= strobeS1;
            strobeS3 <= strobeS2;
            linkS1   <= linkClk;
            linkS2   <= linkS1;
            linkS3   <= linkS2;
            sampS1   <= sampleOffsetBin;
            sampS2   <= sampS1;
        end
    end

    assign strobeFell = strobeS3 & ~strobeS2;
    assign strobeRose = ~strobeS3 & strobeS2;
    assign clkFall    = linkS3 & ~linkS2;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic ssrBitAt(input logic [11:0] code, input logic [4:0] pos);
        ssrBitAt = code[pos[3:0]];
    endfunction

    ssr_pkg::ssr_state_t state_r;
    logic [4:0]          clkCnt_r;
    logic [4:0]          cntNext;
    logic                roseSeen_r;
    logic [11:0]         code_r;
    logic                holdMode_r;
    logic                powerDown_r;
    logic                dataOut_r;
    logic                dataOe_r;
    logic                pushPend_r;
    logic [11:0]         pushWord_r;

    assign cntNext = clkCnt_r + ssr_pkg::CNT_STEP;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r    <= ssr_pkg::ST_IDLE;
            clkCnt_r   <= ssr_pkg::CNT_ZERO;
            roseSeen_r <= 1'b0;
        end else begin
            case (state_r)
                ssr_pkg::ST_IDLE: begin
                    if (strobeFell) begin
                        state_r    <= ssr_pkg::ST_CONVERT_STROBE;
                        clkCnt_r   <= ssr_pkg::CNT_ZERO;
                        roseSeen_r <= 1'b0;
                    end
                end
                ssr_pkg::ST_CONVERT_STROBE: begin
                    if (strobeFell && roseSeen_r) begin
                        if (clkCnt_r == ssr_pkg::CNT_LAST) begin
                            state_r <= ssr_pkg::ST_LSBF;
                        end else begin
                            state_r <= ssr_pkg::ST_IDLE;
                        end
                    end else begin
                        // A strobe rise must not swallow a clock fall seen in the same cycle.
                        if (strobeRose) begin
                            roseSeen_r <= 1'b1;
                        end
                        if (clkFall) begin
                            if (clkCnt_r == ssr_pkg::CNT_LAST) begin
                                // Strobe stayed high through clock 13: plain end, acquire again.
                                state_r <= ssr_pkg::ST_IDLE;
                            end else begin
                                clkCnt_r <= cntNext;
                                if (cntNext == ssr_pkg::CNT_LAST && !roseSeen_r
                                    && !strobeS2) begin
                                    state_r <= ssr_pkg::ST_PDWN;
                                end
                            end
                        end
                    end
                end
                ssr_pkg::ST_PDWN: begin
                    if (strobeRose) begin
                        state_r <= ssr_pkg::ST_IDLE;
                    end else if (clkFall && clkCnt_r != ssr_pkg::CNT_LSB_END) begin
                        clkCnt_r <= cntNext;
                    end
                end
                ssr_pkg::ST_LSBF: begin
                    if (strobeRose) begin
                        state_r <= ssr_pkg::ST_IDLE;
                    end else if (clkFall && clkCnt_r != ssr_pkg::CNT_LSB_END) begin
                        clkCnt_r <= cntNext;
                    end
                end
                default: begin
                    state_r <= ssr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Sample capture, hold and power-down
    // ------------------------------------------------------------------
    // The quantiser delivers offset binary; flipping the top bit gives two's complement.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            code_r <= ssr_pkg::CODE_RESET;
        end else if (state_r == ssr_pkg::ST_IDLE && strobeFell) begin
            code_r <= sampS2 ^ ssr_pkg::TWOS_FLIP;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            holdMode_r <= 1'b0;
        end else if (strobeFell) begin
            holdMode_r <= 1'b1;
        end else if (strobeRose) begin
            holdMode_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            powerDown_r <= 1'b0;
        end else if (strobeRose) begin
            powerDown_r <= 1'b0;
        end else if (state_r == ssr_pkg::ST_CONVERT_STROBE && strobeFell && roseSeen_r
                     && clkCnt_r == ssr_pkg::CNT_LAST) begin
            powerDown_r <= 1'b1;
        end else if (state_r == ssr_pkg::ST_CONVERT_STROBE && clkFall && !roseSeen_r && !strobeS2
                     && cntNext == ssr_pkg::CNT_LAST) begin
            powerDown_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Serial data output
    // ------------------------------------------------------------------
    // A strobe fall outranks a clock edge in the same cycle so the pin is freed at once.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dataOut_r <= 1'b0;
            dataOe_r  <= 1'b0;
        end else if (strobeFell) begin
            dataOe_r <= 1'b0;
        end else if (clkFall) begin
            if (state_r == ssr_pkg::ST_CONVERT_STROBE && clkCnt_r != ssr_pkg::CNT_LAST) begin
                dataOe_r <= 1'b1;
                if (cntNext == ssr_pkg::CNT_NULL) begin
                    dataOut_r <= 1'b0;
                end else begin
                    dataOut_r <= ssrBitAt(code_r, ssr_pkg::CNT_LAST - cntNext);
                end
            end else if (state_r == ssr_pkg::ST_LSBF && clkCnt_r != ssr_pkg::CNT_LSB_END) begin
                dataOe_r  <= 1'b1;
                dataOut_r <= ssrBitAt(code_r, cntNext - ssr_pkg::CNT_LAST);
            end else begin
                dataOe_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Completed results into the buffer
    // ------------------------------------------------------------------
    ssr_stream_if #(.WIDTH(ssr_pkg::RES_BITS)) fillIf ();
    ssr_stream_if #(.WIDTH(ssr_pkg::RES_BITS)) drainIf ();

    // A new completion wins over the hand-off clear in the same cycle.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pushPend_r <= 1'b0;
            pushWord_r <= ssr_pkg::CODE_RESET;
        end else if (state_r == ssr_pkg::ST_CONVERT_STROBE && clkFall && !strobeFell
                     && cntNext == ssr_pkg::CNT_LAST) begin
            pushPend_r <= 1'b1;
            pushWord_r <= code_r;
        end else if (fillIf.ready) begin
            pushPend_r <= 1'b0;
        end
    end

    assign fillIf.valid  = pushPend_r;
    assign fillIf.data   = pushWord_r;
    assign drainIf.ready = resultReady;

    ssr_pair_buffer #(.WIDTH(ssr_pkg::RES_BITS)) resultBuf (
        .clk       (clk),
        .reset     (reset),
        .fillSide  (fillIf),
        .drainSide (drainIf)
    );

    assign dataOut     = dataOut_r;
    assign dataOe      = dataOe_r;
    assign holdMode    = holdMode_r;
    assign powerDown   = powerDown_r;
    assign resultValid = drainIf.valid;
    assign resultWord  = drainIf.data;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    strobe_release_a: assert property (strobeFell |=> !dataOe_r)
        else $error("data not released after strobe fall");
    hold_entry_a: assert property (strobeFell |=> holdMode_r)
        else $error("hold not entered on strobe fall");
    lsb_entry_a: assert property (state_r == ssr_pkg::ST_CONVERT_STROBE && strobeFell && roseSeen_r
        && clkCnt_r == ssr_pkg::CNT_LAST |=> state_r == ssr_pkg::ST_LSBF && powerDown_r)
        else $error("repeat mode not entered");
    lsb_power_a: assert property (state_r == ssr_pkg::ST_LSBF && !strobeRose
        |=> powerDown_r)
        else $error("power-down lost in repeat mode");
    lsb_bits_a: assert property (state_r == ssr_pkg::ST_LSBF && clkFall && !strobeFell
        && !strobeRose && clkCnt_r != ssr_pkg::CNT_LSB_END
        |=> dataOe_r && dataOut_r == code_r[$past(cntNext[3:0]) - 4'hD])
        else $error("repeat bit wrong");
    abort_convert_strobe_a: assert property (state_r == ssr_pkg::ST_CONVERT_STROBE && strobeFell && roseSeen_r
        && clkCnt_r < ssr_pkg::CNT_LAST |=> state_r == ssr_pkg::ST_IDLE ##1 !dataOe_r)
        else $error("short-cycle did not abort");
    auto_pdown_a: assert property (state_r == ssr_pkg::ST_CONVERT_STROBE && clkFall && !strobeFell
        && !strobeRose && !roseSeen_r && !strobeS2 && cntNext == ssr_pkg::CNT_LAST
        |=> powerDown_r && dataOe_r && dataOut_r == code_r[0])
        else $error("no power-down at clock 13");
    msb_bits_a: assert property (state_r == ssr_pkg::ST_CONVERT_STROBE && clkFall && !strobeFell
        && !strobeRose && cntNext > ssr_pkg::CNT_NULL && clkCnt_r != ssr_pkg::CNT_LAST
        |=> dataOe_r && dataOut_r == code_r[4'hD - $past(cntNext[3:0])])
        else $error("normal bit wrong");
    twos_code_a: assert property (state_r == ssr_pkg::ST_IDLE && strobeFell
        |=> code_r == {~$past(sampS2[11]), $past(sampS2[10:0])})
        else $error("result not two's complement");
endmodule

/* File: include/ssr_pkg.sv */
// Shared constants and types for the serial result readout block.
package ssr_pkg;
    // ------------------------------------------------------------------
    // Result format
    // ------------------------------------------------------------------
    localparam int          RES_BITS    = 12;
    localparam logic [11:0] TWOS_FLIP   = 12'h800;
    localparam logic [11:0] CODE_RESET  = 12'h000;

    // ------------------------------------------------------------------
    // Clock counts after the strobe falls
    // ------------------------------------------------------------------
    localparam logic [4:0]  CNT_ZERO    = 5'h00;
    localparam logic [4:0]  CNT_STEP    = 5'h01;
    localparam logic [4:0]  CNT_NULL    = 5'h01;
    localparam logic [4:0]  CNT_LAST    = 5'h0D;
    localparam logic [4:0]  CNT_LSB_END = 5'h18;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CONVERT_STROBE = 4'h2,
        ST_PDWN = 4'h4,
        ST_LSBF = 4'h8
    } ssr_state_t;
endpackage

/* File: include/ssr_stream_if.sv */
// Valid and ready stream carrier between the sequencer and its buffer.
`timescale 1ns/10ps
interface ssr_stream_if #(parameter int WIDTH = 12);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: rtl/ssr_pair_buffer.sv */
// Two-entry buffer with registered outputs for completed results.
`timescale 1ns/10ps
module ssr_pair_buffer #(
    parameter int WIDTH = 12
) (
    input  wire logic  clk,
    input  wire logic  reset,
    ssr_stream_if.snk  fillSide,
    ssr_stream_if.src  drainSide
);
    logic             outValid_r;
    logic [WIDTH-1:0] outData_r;
    logic             skidValid_r;
    logic [WIDTH-1:0] skidData_r;
    logic             push;

    // A full skid slot stalls the producer, so no word is ever dropped here.
    assign fillSide.ready  = ~skidValid_r;
    assign push            = fillSide.valid & ~skidValid_r;
    assign drainSide.valid = outValid_r;
    assign drainSide.data  = outData_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            outValid_r  <= 1'b0;
            outData_r   <= '0;
            skidValid_r <= 1'b0;
            skidData_r  <= '0;
        end else if (!outValid_r || drainSide.ready) begin
            if (skidValid_r) begin
                outValid_r  <= 1'b1;
                outData_r   <= skidData_r;
                skidValid_r <= 1'b0;
            end else begin
                outValid_r <= push;
                outData_r  <= fillSide.data;
            end
        end else if (push) begin
            skidValid_r <= 1'b1;
            skidData_r  <= fillSide.data;
        end
    end
endmodule

/* File: verif/ssr_host_model.sv */
// Host model: drives the strobe and the gated serial clock and samples the data pin.
`timescale 1ns/10ps
module ssr_host_model (
    input  wire logic clk,
    input  wire logic dataOut,
    input  wire logic dataOe,
    output logic      convertStrobe,
    output logic      linkClk
);
    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    // The serial clock idles high between frames; it is gated, not free running.
    initial begin
        convertStrobe = 1'b1;
        linkClk       = 1'b1;
    end

    task automatic waitClk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Strobe rise ends power-down and returns the converter to acquisition.
    task automatic raise();
        convertStrobe = 1'b1;
        waitClk(8);
    endtask

    // One frame of nFalls serial clocks of 160 ns. The strobe goes up after fall upAt
    // and down after fall downAt; each bit is latched before the strobe moves.
    task automatic frame(input int nFalls, input int upAt, input int downAt,
                         output logic [31:0] bits, output logic [31:0] oes);
        bits = '0;
        oes  = '0;
        convertStrobe = 1'b1;
        waitClk(8);
        convertStrobe = 1'b0;
        waitClk(10);
        for (int f = 1; f <= nFalls; f++) begin
            linkClk = 1'b0;
            waitClk(4);
            linkClk = 1'b1;
            waitClk(4);
            bits[f] = dataOut;
            oes[f]  = dataOe;
            if (f == upAt) begin
                convertStrobe = 1'b1;
                waitClk(4);
            end
            if (f == downAt) begin
                convertStrobe = 1'b0;
                waitClk(4);
                oes[0] = dataOe;
            end
        end
    endtask
endmodule

/* File: verif/test_sar_adc_serial_readout.sv */
// Self-checking testbench of the serial result readout block.
`timescale 1ns/10ps
module test_sar_adc_serial_readout;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic        clk             = 1'b0;
    logic        reset           = 1'b1;
    logic [11:0] sampleOffsetBin = 12'h000;
    logic        resultReady     = 1'b0;
    logic        stall           = 1'b1;
    logic [15:0] lfsr            = 16'h005A;
    logic        convertStrobe;
    logic        linkClk;
    logic        dataOut;
    logic        dataOe;
    logic        holdMode;
    logic        powerDown;
    logic        resultValid;
    logic [11:0] resultWord;
    logic [11:0] expQ[$];
    int          nErrors         = 0;
    int          nTests          = 0;

    ssr_serial_readout ssr_serial_readout_inst (
        .clk             (clk),
        .reset           (reset),
        .convertStrobe   (convertStrobe),
        .linkClk         (linkClk),
        .sampleOffsetBin (sampleOffsetBin),
        .dataOut         (dataOut),
        .dataOe          (dataOe),
        .holdMode        (holdMode),
        .powerDown       (powerDown),
        .resultValid     (resultValid),
        .resultWord      (resultWord),
        .resultReady     (resultReady)
    );

    ssr_host_model ssr_host_model_inst (
        .clk           (clk),
        .dataOut       (dataOut),
        .dataOe        (dataOe),
        .convertStrobe (convertStrobe),
        .linkClk       (linkClk)
    );

    always #10 clk = ~clk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] lfsrNext(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Expected {enables, bits} of a frame: mode 0 normal, 1 repeat, 2 aborted after fall k.
    function automatic logic [63:0] expFrame(input logic [11:0] w, input int mode,
                                             input int k, input int nF);
        logic [31:0] eo;
        logic [31:0] eb;
        eo = '0;
        eb = '0;
        for (int f = 1; f <= nF; f++) begin
            eo[f] = (mode == 2) ? (f <= k) : ((mode == 1) ? (f <= 24) : (f <= 13));
            eb[f] = (f == 1) ? 1'b0 : ((f <= 13) ? w[13 - f] : w[f - 13]);
        end
        return {eo, eb & eo};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            nErrors++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic endOfTest();
        if (nErrors == 0 && nTests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Runs one frame; w is the expected two's complement result.
    task automatic runFrame(input logic [11:0] w, input int mode, input int k);
        logic [31:0] bits;
        logic [31:0] oes;
        logic [63:0] e;
        int          nF;
        nF = (mode == 0) ? 16 : ((mode == 1) ? 25 : k + 2);
        e = expFrame(w, mode, k, nF);
        sampleOffsetBin = w ^ 12'h800;
        if (mode != 2) begin
            expQ.push_back(w);
        end
        ssr_host_model_inst.frame(nF, (mode == 1) ? 12 : k, (mode == 1) ? 13 : k, bits, oes);
        check(oes, e[63:32]);
        check(bits & e[63:32], e[31:0]);
        check(powerDown, (mode != 2) ? 32'h0000_0001 : 32'h0000_0000);
        if (mode != 2) begin
            check(holdMode, 32'h0000_0001);
        end
        ssr_host_model_inst.raise();
        check(powerDown, 32'h0000_0000);
        check(holdMode, 32'h0000_0000);
    endtask

    // ------------------------------------------------------------------
    // Result consumer with random stalls
    // ------------------------------------------------------------------
    // The word is judged at the falling edge before the rising edge that takes it,
    // so the buffer's own update at that rising edge cannot race the check.
    always @(negedge clk) begin
        lfsr <= lfsrNext(lfsr);
        resultReady <= !stall && lfsr[0];
        if (resultValid === 1'b1 && !stall && lfsr[0]) begin
            if (expQ.size() == 0) begin
                check(resultWord, 32'hFFFF_FFFF);
            end else begin
                check(resultWord, expQ.pop_front());
            end
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    // The watchdog cuts a hang short; every frame is a bounded count of clocks.
    initial begin
        repeat (60000) @(posedge clk);
        nErrors++;
        endOfTest();
    end

    initial begin
        logic [11:0] corner[4];
        int          waitCnt;
        corner = '{12'h7FF, 12'h000, 12'hFFF, 12'h800};
        repeat (12) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        // Three results wait while the consumer stalls, two in the buffer and one in pushWord_r, then drain.
        for (int i = 0; i < 4; i++) begin
            if (i == 3) begin
                stall = 1'b0;
            end
            runFrame(corner[i], 0, 0);
        end
        repeat (6) runFrame(lfsr[11:0], 0, 0);
        runFrame(12'h800, 1, 0);
        runFrame(lfsr[11:0], 1, 0);
        runFrame(lfsr[11:0], 2, 6);
        runFrame(lfsr[11:0], 2, 12);
        runFrame(lfsr[11:0], 0, 0);
        waitCnt = 0;
        while (expQ.size() != 0 && waitCnt < 400) begin
            @(negedge clk);
            waitCnt++;
        end
        check(expQ.size(), 32'h0000_0000);
        endOfTest();
    end
endmodule
